// [include/sstat_consts.vh]
/*
 Constants of the serial status flag block: bit positions, reset value,
 register offsets and frame geometry.
 Assumes inclusion by bare name from the single design file.
*/
// Functional notes
// [RULE1] Eight-bit status register resets to 0x84
// [RULE2] Software writes of one never set flags
// [RULE3] Zero clears flag only after read as one
// [RULE4] Transmit end and received multiproc bit read-only
// [RULE5] Tx empty set: reset, standby, disable, load
// [RULE6] Tx empty cleared by armed zero write
// [RULE7] Rx full set on clean character transfer
// [RULE8] Rx full cleared: reset, armed write, dma read
// [RULE9] Errors and rx disable keep buffer, full flag
// [RULE10] Overrun when receiving while rx full; discard
// [RULE11] Error flags halt reception; sync also transmit
// [RULE12] Framing error when async stop bit zero
// [RULE13] Only first of two stop bits checked
// [RULE14] Errored character stored, rx full not set
// [RULE15] Parity error on parity count mismatch
// [RULE16] Error flags cleared only by reset or sequence
// [RULE17] Armed tx empty zero write clears transmit end
// [RULE18] Transmit end set: reset, disable, idle last bit
// [RULE19] Capture received multiproc bit, keep on disable
// [RULE20] Bit zero holds transmit multiproc bit value
// [RULE21] Per-flag arm set on read, consumed on write
`ifndef SSTAT_CONSTS_VH
`define SSTAT_CONSTS_VH
`define SSTAT_RESET_VALUE 8'h84
`define SSTAT_BIT_TDE 7
`define SSTAT_BIT_RDF 6
`define SSTAT_BIT_OVR 5
`define SSTAT_BIT_FRM 4
`define SSTAT_BIT_PAR 3
`define SSTAT_BIT_TX_END 2
`define SSTAT_BIT_RMP 1
`define SSTAT_BIT_TMP 0
`define SSTAT_ADDR_W 2
`define SSTAT_OFF_STATUS 2'h0
`define SSTAT_OFF_RXBUF 2'h1
`define SSTAT_OFF_TXBUF 2'h2
`define SSTAT_OFF_CTRL 2'h3
`define SSTAT_CTRL_TXEN 0
`define SSTAT_CTRL_RXEN 1
`define SSTAT_CTRL_PODD 2
`define SSTAT_CTRL_SYNC 3
`define SSTAT_CTRL_MP 4
`define SSTAT_CTRL_TWOSTOP 5
`define SSTAT_FRAME_W 11
`define SSTAT_ARM_W 5
`define SSTAT_ARM_TDE 4
`define SSTAT_ARM_RDF 3
`define SSTAT_ARM_OVR 2
`define SSTAT_ARM_FRM 1
`define SSTAT_ARM_PAR 0
`define SSTAT_ZERO8 8'h00
`endif

// [rtl/sstat_flags.v]
/*
 Status flag logic of a serial channel: status register, buffers,
 read-then-zero clearing and dma read clearing.
 Assumes the shift engines report events as one-cycle pulses on core_clk
 and present the received frame (data, parity, mp bit, two stop bits).
*/
`timescale 1ns/1ps
`include "sstat_consts.vh"
module sstat_flags (
  input wire core_clk,
  input wire rst_b,
  input wire standby,
  input wire [1:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire tx_load,
  input wire tx_last_bit,
  input wire rx_complete,
  input wire [7:0] rx_data,
  input wire rx_parity_bit,
  input wire rx_mp_bit,
  input wire rx_stop1,
  input wire rx_stop2,
  input wire dma_rx_read,
  output reg [7:0] tx_buffer_out,
  output reg tx_multiproc_out,
  output reg tx_go,
  output reg rx_halt,
  output reg tx_halt
);
  localparam [7:0] RST_VAL = `SSTAT_RESET_VALUE;
  // Reset and standby share one synchronous initialisation
  wire init = !rst_b || standby;
  wire tx_buffer_empty;
  wire rx_buffer_full;
  wire overrun_error;
  wire framing_error;
  wire parity_error;
  wire tx_end;
  reg rx_multiproc_bit;
  reg tx_multiproc_bit;
  reg [7:0] rx_buffer;
  reg [7:0] tx_buffer;
  reg [7:0] serial_control;
  reg [`SSTAT_ARM_W-1:0] arm;
  reg [`SSTAT_ARM_W-1:0] next_arm;
  reg next_rx_multiproc_bit;
  reg next_tx_multiproc_bit;
  reg [7:0] next_rx_buffer;
  reg [7:0] next_tx_buffer;
  reg [7:0] next_serial_control;
  reg [7:0] next_reg_rdata;

  wire [7:0] status = {tx_buffer_empty, rx_buffer_full, overrun_error, framing_error,
    parity_error, tx_end, rx_multiproc_bit, tx_multiproc_bit};
  wire [`SSTAT_ARM_W-1:0] armable = status[`SSTAT_BIT_TDE:`SSTAT_BIT_PAR];

  wire tx_en = serial_control[`SSTAT_CTRL_TXEN];
  wire rx_en = serial_control[`SSTAT_CTRL_RXEN];
  wire odd_parity = serial_control[`SSTAT_CTRL_PODD];
  wire sync_mode = serial_control[`SSTAT_CTRL_SYNC];
  wire mp_mode = serial_control[`SSTAT_CTRL_MP] & ~sync_mode;

  wire st_wr = reg_wr && (reg_addr == `SSTAT_OFF_STATUS);
  wire st_rd = reg_rd && (reg_addr == `SSTAT_OFF_STATUS);
  wire txbuf_wr = reg_wr && (reg_addr == `SSTAT_OFF_TXBUF);
  wire ctrl_wr = reg_wr && (reg_addr == `SSTAT_OFF_CTRL);

  // Flag cleared by a zero write only when armed; rx full also by dma read
  wire clr_tde = st_wr & ~reg_wdata[`SSTAT_BIT_TDE] & arm[`SSTAT_ARM_TDE]; // [RULE3] [RULE6]
  wire clr_rdf = st_wr & ~reg_wdata[`SSTAT_BIT_RDF] & arm[`SSTAT_ARM_RDF]; // [RULE3]
  wire clr_ovr = st_wr & ~reg_wdata[`SSTAT_BIT_OVR] & arm[`SSTAT_ARM_OVR]; // [RULE3]
  wire clr_frm = st_wr & ~reg_wdata[`SSTAT_BIT_FRM] & arm[`SSTAT_ARM_FRM]; // [RULE3]
  wire clr_par = st_wr & ~reg_wdata[`SSTAT_BIT_PAR] & arm[`SSTAT_ARM_PAR]; // [RULE3]

  wire any_err = overrun_error | framing_error | parity_error;
  wire rx_ok = rx_complete & rx_en & ~any_err; // [RULE11]
  wire frm_bad = ~sync_mode & ~rx_stop1; // [RULE12] [RULE13]
  wire rx_ones = ^{rx_data, rx_parity_bit};
  // Parity is good when the count of ones matches the odd selection
  wire par_bad = ~sync_mode & (rx_ones ^ odd_parity); // [RULE15]
  wire ovr_hit = rx_ok & rx_buffer_full; // [RULE10]
  wire rx_store = rx_ok & ~rx_buffer_full;
  wire rx_clean = rx_store & ~frm_bad & ~par_bad; // [RULE7] [RULE14]

  // Writes of one never reach a set term; set wins over clear
  wire set_tde = !tx_en || tx_load; // [RULE5] [RULE2]
  wire set_tx_end = !tx_en || (tx_last_bit && tx_buffer_empty); // [RULE18]
  wire set_frm = rx_store & frm_bad; // [RULE12]
  wire set_par = rx_store & par_bad; // [RULE15]
  wire clr_rdf_any = clr_rdf | dma_rx_read; // [RULE8] [RULE9]

  sstat_flag_cell #(
    .RESET_VAL(RST_VAL[`SSTAT_BIT_TDE])
  ) tde_cell (
    .core_clk(core_clk),
    .init(init),
    .set(set_tde),
    .clr(clr_tde),
    .flag(tx_buffer_empty)
  ); // [RULE1] [RULE6]

  sstat_flag_cell #(
    .RESET_VAL(RST_VAL[`SSTAT_BIT_RDF])
  ) rdf_cell (
    .core_clk(core_clk),
    .init(init),
    .set(rx_clean),
    .clr(clr_rdf_any),
    .flag(rx_buffer_full)
  ); // [RULE7] [RULE8]

  sstat_flag_cell #(
    .RESET_VAL(RST_VAL[`SSTAT_BIT_OVR])
  ) ovr_cell (
    .core_clk(core_clk),
    .init(init),
    .set(ovr_hit),
    .clr(clr_ovr),
    .flag(overrun_error)
  ); // [RULE10] [RULE16]

  sstat_flag_cell #(
    .RESET_VAL(RST_VAL[`SSTAT_BIT_FRM])
  ) frm_cell (
    .core_clk(core_clk),
    .init(init),
    .set(set_frm),
    .clr(clr_frm),
    .flag(framing_error)
  ); // [RULE12] [RULE16]

  sstat_flag_cell #(
    .RESET_VAL(RST_VAL[`SSTAT_BIT_PAR])
  ) par_cell (
    .core_clk(core_clk),
    .init(init),
    .set(set_par),
    .clr(clr_par),
    .flag(parity_error)
  ); // [RULE15] [RULE16]

  // Transmit end shares the armed transmit-empty clear
  sstat_flag_cell #(
    .RESET_VAL(RST_VAL[`SSTAT_BIT_TX_END])
  ) tx_end_cell (
    .core_clk(core_clk),
    .init(init),
    .set(set_tx_end),
    .clr(clr_tde),
    .flag(tx_end)
  ); // [RULE17] [RULE4]

  // Read arms set bits; any status write consumes every arm
  always @* begin
    next_arm = arm;
    if (st_wr)
      next_arm = {`SSTAT_ARM_W{1'b0}}; // [RULE21]
    else if (st_rd)
      next_arm = arm | armable; // [RULE21]
  end

  always @* begin
    next_rx_multiproc_bit = rx_multiproc_bit;
    if (rx_store && mp_mode)
      next_rx_multiproc_bit = rx_mp_bit; // [RULE19]
  end

  always @* begin
    next_tx_multiproc_bit = tx_multiproc_bit;
    if (st_wr)
      next_tx_multiproc_bit = reg_wdata[`SSTAT_BIT_TMP]; // [RULE20]
  end

  // Overrun discards new data; errored data still stored
  always @* begin
    next_rx_buffer = rx_buffer;
    if (rx_store)
      next_rx_buffer = rx_data; // [RULE14] [RULE10]
  end

  always @* begin
    next_tx_buffer = tx_buffer;
    if (txbuf_wr)
      next_tx_buffer = reg_wdata;
  end

  always @* begin
    next_serial_control = serial_control;
    if (ctrl_wr)
      next_serial_control = reg_wdata;
  end

  // Read data stands only in the cycle after the strobe
  always @* begin
    next_reg_rdata = `SSTAT_ZERO8;
    if (reg_rd) begin
      if (reg_addr == `SSTAT_OFF_STATUS)
        next_reg_rdata = status;
      else if (reg_addr == `SSTAT_OFF_RXBUF)
        next_reg_rdata = rx_buffer;
      else if (reg_addr == `SSTAT_OFF_TXBUF)
        next_reg_rdata = tx_buffer;
      else
        next_reg_rdata = serial_control;
    end
  end

  always @(posedge core_clk) begin
    if (init)
      arm <= {`SSTAT_ARM_W{1'b0}};
    else
      arm <= next_arm;
  end

  always @(posedge core_clk) begin
    if (init)
      rx_multiproc_bit <= RST_VAL[`SSTAT_BIT_RMP]; // [RULE1]
    else
      rx_multiproc_bit <= next_rx_multiproc_bit;
  end

  always @(posedge core_clk) begin
    if (init)
      tx_multiproc_bit <= RST_VAL[`SSTAT_BIT_TMP]; // [RULE1]
    else
      tx_multiproc_bit <= next_tx_multiproc_bit;
  end

  always @(posedge core_clk) begin
    if (init)
      rx_buffer <= `SSTAT_ZERO8;
    else
      rx_buffer <= next_rx_buffer;
  end

  always @(posedge core_clk) begin
    if (init)
      tx_buffer <= `SSTAT_ZERO8;
    else
      tx_buffer <= next_tx_buffer;
  end

  always @(posedge core_clk) begin
    if (init)
      serial_control <= `SSTAT_ZERO8;
    else
      serial_control <= next_serial_control;
  end

  always @(posedge core_clk) begin
    if (init)
      reg_rdata <= `SSTAT_ZERO8;
    else
      reg_rdata <= next_reg_rdata;
  end

  always @(posedge core_clk) begin
    if (init)
      tx_buffer_out <= `SSTAT_ZERO8;
    else
      tx_buffer_out <= tx_buffer;
  end

  always @(posedge core_clk) begin
    if (init)
      tx_multiproc_out <= 1'b0;
    else
      tx_multiproc_out <= tx_multiproc_bit & mp_mode; // [RULE20]
  end

  // Engine starts a character once software cleared tx empty
  always @(posedge core_clk) begin
    if (init)
      tx_go <= 1'b0;
    else
      tx_go <= tx_en & ~tx_buffer_empty & ~(sync_mode & any_err);
  end

  always @(posedge core_clk) begin
    if (init)
      rx_halt <= 1'b0;
    else
      rx_halt <= any_err | ~rx_en; // [RULE11]
  end

  always @(posedge core_clk) begin
    if (init)
      tx_halt <= 1'b0;
    else
      tx_halt <= sync_mode & any_err; // [RULE11]
  end
endmodule

// Sticky flag: set beats clear when both fall in one cycle
module sstat_flag_cell #(
  parameter [0:0] RESET_VAL = 1'b0
) (
  input wire core_clk,
  input wire init,
  input wire set,
  input wire clr,
  output reg flag
);
  reg next_flag;

  always @* begin
    next_flag = flag;
    if (set)
      next_flag = 1'b1;
    else if (clr)
      next_flag = 1'b0;
  end

  always @(posedge core_clk) begin
    if (init)
      flag <= RESET_VAL;
    else
      flag <= next_flag;
  end
endmodule

// [sim/sstat_remote.sv]
/* Far-side shift engines: received frames and transmit events.
 Tasks start just after a core_clk edge. */
`timescale 1ns/1ps
module sstat_remote (
  input wire core_clk,
  output reg rx_complete, tx_load, tx_last_bit, rx_parity_bit, rx_mp_bit, rx_stop1, rx_stop2,
  output reg [7:0] rx_data
);
  initial {rx_complete, tx_load, tx_last_bit, rx_parity_bit, rx_mp_bit, rx_stop1, rx_stop2, rx_data} = 15'h0;
  task frame(input [7:0] d, input [1:0] bad);
    {rx_complete, rx_data, rx_mp_bit, rx_stop2} <= {1'b1, d, d[7], 1'b0};
    {rx_parity_bit, rx_stop1} <= {^d ^ bad[1], ~bad[0]};
    @(posedge core_clk);
    {rx_complete, rx_data} <= {1'b0, ~d};
    #1;
  endtask
  task pulse(input last);
    {tx_last_bit, tx_load} <= {last, !last};
    @(posedge core_clk);
    {tx_last_bit, tx_load} <= 2'h0;
    #1;
  endtask
endmodule

// [sim/sstat_flags_assertions.sv]
/* Port checker of sstat_flags.
 Bound to every instance below; sees its ports only. */
`timescale 1ns/1ps
module sstat_chk (
  input wire core_clk, rst_b, standby, reg_rd, tx_load, rx_complete, dma_rx_read, tx_go, rx_halt, tx_halt,
  input wire [1:0] reg_addr,
  input wire [7:0] reg_rdata
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b || standby);
  wire rd0 = reg_rd && reg_addr == 2'h0;
  a_reset_value: assert property (disable iff (1'b0)
    (!rst_b || standby) ##1 (rst_b && !standby && rd0) |=> reg_rdata == 8'h84) else $error("bad reset value");
  a_load_sets_empty: assert property (tx_load ##1 rd0 |=> reg_rdata[7]) else $error("empty not set");
  a_dma_clears_full: assert property (dma_rx_read && !rx_complete ##1 rd0 |=> !reg_rdata[6]) else $error("full kept");
  a_overrun_sticks: assert property (rd0 ##1 (rd0 && reg_rdata[5]) |=> reg_rdata[5]) else $error("overrun lost");
  a_error_halts_rx: assert property (rd0 ##1 |reg_rdata[5:3] |-> rx_halt) else $error("rx not halted");
  a_empty_blocks_tx: assert property (rd0 ##1 reg_rdata[7] |-> !tx_go) else $error("tx while empty");
  a_tx_halt_rx: assert property (tx_halt |-> rx_halt) else $error("halts disagree");
  a_halt_stops_go: assert property (tx_halt |-> !tx_go) else $error("go while halted");
  c_overrun: cover property (rd0 ##1 reg_rdata[5]);
  c_dma: cover property (dma_rx_read);
  c_sync_halt: cover property (tx_halt);
endmodule
bind sstat_flags sstat_chk sstat_chk_inst (.*);

// [sim/sstat_flags_test.sv]
/* Self-checking bench of sstat_flags with the far-side model.
 Assumes the checker binds itself to the design. */
`timescale 1ns/1ps
module sstat_flags_test;
  reg core_clk, rst_b, standby, reg_wr, reg_rd, dma_rx_read;
  reg [1:0] reg_addr;
  reg [7:0] reg_wdata;
  reg [31:0] rnd = 32'hb9b01db3;
  wire rx_complete, tx_load, tx_last_bit, rx_parity_bit, rx_mp_bit, rx_stop1, rx_stop2;
  wire tx_multiproc_out, tx_go, rx_halt, tx_halt;
  wire [7:0] rx_data, reg_rdata, tx_buffer_out;
  integer mismatches = 0, total_checks = 0, i;
  always #2 core_clk = ~core_clk;
  sstat_remote sstat_remote_inst (.*);
  sstat_flags sstat_flags_inst (.*);
  function [7:0] rx_exp(input [7:0] v);
    rx_exp = {6'h10, v[7], 1'b0};
  endfunction
  task chk(input [7:0] g, e);
    total_checks = total_checks + 1;
    if (g !== e) begin
      mismatches = mismatches + 1;
      $display("CHECK FAILED %0t got %h want %h", $time, g, e);
    end
  endtask
  task wr(input [1:0] a, input [7:0] v);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task rd(input [1:0] a, input [7:0] e, m);
    {reg_rd, reg_addr, dma_rx_read} <= {1'b1, a, 1'b0};
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata & m, e);
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #4000 mismatches = mismatches + 1;
    give_verdict;
  end
  initial begin
    {core_clk, rst_b, standby, reg_wr, reg_rd, dma_rx_read, reg_addr, reg_wdata} = 16'h0;
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    rd(0, 8'h84, 8'hff);
    wr(0, 8'hff);
    rd(0, 8'h85, 8'hff);
    wr(3, 8'h13);
    wr(2, 8'h5a);
    chk({7'h0, tx_multiproc_out}, 8'h01);
    wr(0, 8'h00);
    rd(0, 8'h00, 8'hff);
    chk({tx_go, tx_buffer_out[6:0]}, 8'hda);
    sstat_remote_inst.pulse(0);
    rd(0, 8'h80, 8'h84);
    sstat_remote_inst.pulse(1);
    rd(0, 8'h84, 8'h84);
    for (i = 0; i < 8; i = i + 1) begin
      rnd = rnd ^ (rnd << 13);
      rnd = rnd ^ (rnd >> 17);
      rnd = rnd ^ (rnd << 5);
      sstat_remote_inst.frame(rnd[7:0], 2'h0);
      rd(0, rx_exp(rnd[7:0]), 8'h7a);
      rd(1, rnd[7:0], 8'hff);
      dma_rx_read <= 1'b1;
      @(posedge core_clk);
      rd(0, 8'h00, 8'h40);
    end
    sstat_remote_inst.frame(8'h11, 2'h0);
    sstat_remote_inst.frame(8'h22, 2'h0);
    sstat_remote_inst.frame(8'h33, 2'h1);
    wr(3, 8'h11);
    rd(0, 8'h60, 8'h78);
    rd(0, 8'h60, 8'h78);
    wr(3, 8'h1b);
    rd(1, 8'h11, 8'hff);
    chk({6'h0, rx_halt, tx_halt}, 8'h03);
    wr(3, 8'h13);
    wr(0, 8'h00);
    rd(0, 8'h00, 8'h78);
    sstat_remote_inst.frame(8'h44, 2'h1);
    rd(0, 8'h10, 8'h78);
    rd(1, 8'h44, 8'hff);
    wr(0, 8'h00);
    sstat_remote_inst.frame(8'h55, 2'h2);
    wr(0, 8'h00);
    rd(0, 8'h08, 8'h78);
    wr(0, 8'h00);
    rd(0, 8'h00, 8'h78);
    wr(3, 8'h37);
    sstat_remote_inst.frame(8'h66, 2'h2);
    rd(0, 8'h40, 8'h78);
    rd(1, 8'h66, 8'hff);
    standby <= 1'b1;
    @(posedge core_clk);
    standby <= 1'b0;
    rd(0, 8'h84, 8'hff);
    give_verdict;
  end
endmodule
